// >>> design/rx_ctrl_regs.vh
// Purpose: constants for the receiver control bus interface
// Assumes: eight-bit bus addresses, 200 MHz clock
// Notes:   strobe decode codes and delay timings
`ifndef RX_CTRL_REGS_VH
`define RX_CTRL_REGS_VH
// ----------------------------------------
// strobe decoder one codes
// ----------------------------------------
`define ADDR_B0 8'hb0
`define ADDR_B2 8'hb2
`define ADDR_B4 8'hb4
`define ADDR_B6 8'hb6
// ----------------------------------------
// strobe decoder two codes
// ----------------------------------------
`define ADDR_90 8'h90
`define ADDR_92 8'h92
`define ADDR_96 8'h96
`define ADDR_9A 8'h9a
`define ADDR_B8 8'hb8
`define ADDR_BA 8'hba
`define ADDR_BC 8'hbc
// ----------------------------------------
// strobe bit positions
// ----------------------------------------
`define RD1_B0 0
`define RD1_B2 1
`define RD1_B4 2
`define WR1_B0 0
`define WR1_B2 1
`define WR1_B4 2
`define WR1_B6 3
`define RD2_96 0
`define RD2_9A 1
`define WR2_90 0
`define WR2_92 1
`define WR2_B8 2
`define WR2_BA 3
`define WR2_BC 4
// ----------------------------------------
// timing, ns and cycles at 5 ns
// ----------------------------------------
`define CLK_PERIOD_NS      5
`define SAMPLE_DELAY_NS    20
`define FINE_DELAY_NS      40
`define SAMPLE_WIDTH_NS    20
`define MULT_DELAY_NS      30
`define SAMPLE_DELAY_CYC   ((`SAMPLE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FINE_DELAY_CYC     ((`FINE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_WIDTH_CYC   ((`SAMPLE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MULT_DELAY_CYC     ((`MULT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> design/rx_ctrl_bus.v
// Purpose: receiver flag select, test decode, fine sample latch, strobe decode
// Assumes: one clock, synchronous reset; all pins pass two flip-flops
// Notes:   outputs are registered; pod flags arrive as two-bit pairs
//
// Contract
// RULE1: pass one pod flag per set by select
// RULE2: forward continuous wave and sideband flags
// RULE3: forward pulse width reset and start trigger
// RULE4: decode data bits 0-2 into five tests
// RULE5: latch fine frequency word onto bits 8-15
// RULE6: multiplier controls from delayed events and logic
// RULE7: sample clocks from retrigger, delayed, gated
// RULE8: buffer address bits to both decoders
// RULE9: decoder one read B0 B2 B4, write B0-B6
// RULE10: decoder two read 96 9A, write 90 92 B8 BA BC
// RULE11: decoders idle without load commands
// RULE12: load commands from strobes and memory enable, acknowledge
// RULE13: sideband flag into two addressed byte buffers
// RULE14: only strobed buffer drives its data
// RULE15: partner supplies memory access enable
// RULE16: unmatched addresses give no strobe
`timescale 1ns/1ps
`include "rx_ctrl_regs.vh"
module rx_ctrl_bus #(
   parameter SAMPLE_DELAY = `SAMPLE_DELAY_CYC,
   parameter FINE_DELAY   = `FINE_DELAY_CYC,
   parameter SAMPLE_WIDTH = `SAMPLE_WIDTH_CYC,
   parameter MULT_DELAY   = `MULT_DELAY_CYC
) (
   input  wire       clk,
   input  wire       reset,
   input  wire       pod_select,
   input  wire [1:0] continuous_wave_flag_in,
   input  wire [1:0] sideband_flag_in,
   input  wire [1:0] pulse_width_reset_in,
   input  wire [1:0] start_trigger_in,
   input  wire [2:0] bus_data_low,
   input  wire [7:0] fine_freq_sample_bits,
   input  wire [7:0] bus_address_bits,
   input  wire       read_strobe_in,
   input  wire       write_strobe_in,
   input  wire       memory_access_enable,
   input  wire       fine_freq_retrigger,
   input  wire       pulse_gate_enable,
   input  wire       fine_buffer_strobe_n,
   input  wire       retrigger_buffer_strobe_n,
   output reg        continuous_wave_flag,
   output reg        sideband_flag,
   output reg        pulse_width_reset,
   output reg        start_trigger,
   output reg  [4:0] test_control,
   output reg  [15:8] fine_freq_bus,
   output reg  [2:0] read_strobe_a,
   output reg  [3:0] write_strobe_a,
   output reg  [1:0] read_strobe_b,
   output reg  [4:0] write_strobe_b,
   output reg        load_acknowledge,
   output reg        phase_sample_clock,
   output reg        fine_freq_sample_clock,
   output reg        mult_load,
   output reg        mult_start,
   output reg  [7:0] fine_buffer_data,
   output reg        fine_buffer_oe,
   output reg  [7:0] retrigger_buffer_data,
   output reg        retrigger_buffer_oe
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
localparam SW = 35;
localparam [SW-1:0] SYNC_IDLE = 35'h3;                 // buffer strobe pins idle high
wire [SW-1:0] raw_in;
reg  [SW-1:0] sync1_reg;
reg  [SW-1:0] sync2_reg;
assign raw_in = {pod_select, continuous_wave_flag_in, sideband_flag_in, pulse_width_reset_in,
                 start_trigger_in, bus_data_low, fine_freq_sample_bits, bus_address_bits,
                 read_strobe_in, write_strobe_in, memory_access_enable, fine_freq_retrigger,
                 pulse_gate_enable, fine_buffer_strobe_n, retrigger_buffer_strobe_n};
always @(posedge clk)
begin
   if (reset)
   begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
   end
   else
   begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
   end
end
wire       s_pod    = sync2_reg[34];
wire [1:0] s_cw     = sync2_reg[33:32];
wire [1:0] s_sb     = sync2_reg[31:30];
wire [1:0] s_pwr    = sync2_reg[29:28];
wire [1:0] s_st     = sync2_reg[27:26];
wire [2:0] s_dlow   = sync2_reg[25:23];
wire [7:0] s_fine   = sync2_reg[22:15];
wire [7:0] s_addr   = sync2_reg[14:7];
wire       s_rd     = sync2_reg[6];
wire       s_wr     = sync2_reg[5];
wire       s_mem    = sync2_reg[4];
wire       s_rtg    = sync2_reg[3];
wire       s_pwg    = sync2_reg[2];
wire       s_fstb_n = sync2_reg[1];
wire       s_rstb_n = sync2_reg[0];

// ----------------------------------------
// helper functions
// ----------------------------------------
function pod_mux;
   input [1:0] pair;
   input       sel;
   begin
      pod_mux = sel ? pair[1] : pair[0];
   end
endfunction

function [4:0] test_decode;
   input [2:0] code;
   begin
      case (code)
         3'h1:    test_decode = 5'h01;
         3'h2:    test_decode = 5'h02;
         3'h3:    test_decode = 5'h04;
         3'h4:    test_decode = 5'h08;
         3'h5:    test_decode = 5'h10;
         default: test_decode = 5'h00;
      endcase
   end
endfunction

// ----------------------------------------
// address buffer and load commands
// ----------------------------------------
reg [7:0] addr_reg;
reg       read_load_reg;
reg       write_load_reg;
always @(posedge clk)
begin
   if (reset)
   begin
      addr_reg       <= 8'h00;
      read_load_reg  <= 1'b0;
      write_load_reg <= 1'b0;
   end
   else
   begin
      addr_reg       <= s_addr;                        // RULE8
      read_load_reg  <= s_rd & ~s_wr & s_mem;          // RULE12
      write_load_reg <= s_wr & ~s_rd & s_mem;          // RULE12
   end
end

// ----------------------------------------
// strobe decoders
// ----------------------------------------
reg [2:0] rd_a_next;
reg [3:0] wr_a_next;
reg [1:0] rd_b_next;
reg [4:0] wr_b_next;
always @*
begin
   rd_a_next = 3'h0;                                   // RULE16
   wr_a_next = 4'h0;
   rd_b_next = 2'h0;
   wr_b_next = 5'h00;
   if (read_load_reg)                                  // RULE11
   begin
      rd_a_next[`RD1_B0] = (addr_reg == `ADDR_B0);     // RULE9
      rd_a_next[`RD1_B2] = (addr_reg == `ADDR_B2);
      rd_a_next[`RD1_B4] = (addr_reg == `ADDR_B4);
      rd_b_next[`RD2_96] = (addr_reg == `ADDR_96);     // RULE10
      rd_b_next[`RD2_9A] = (addr_reg == `ADDR_9A);
   end
   if (write_load_reg)                                 // RULE11
   begin
      wr_a_next[`WR1_B0] = (addr_reg == `ADDR_B0);     // RULE9
      wr_a_next[`WR1_B2] = (addr_reg == `ADDR_B2);
      wr_a_next[`WR1_B4] = (addr_reg == `ADDR_B4);
      wr_a_next[`WR1_B6] = (addr_reg == `ADDR_B6);
      wr_b_next[`WR2_90] = (addr_reg == `ADDR_90);     // RULE10
      wr_b_next[`WR2_92] = (addr_reg == `ADDR_92);
      wr_b_next[`WR2_B8] = (addr_reg == `ADDR_B8);
      wr_b_next[`WR2_BA] = (addr_reg == `ADDR_BA);
      wr_b_next[`WR2_BC] = (addr_reg == `ADDR_BC);
   end
end

// ----------------------------------------
// sample clock and multiplier timing
// ----------------------------------------
reg [7:0] rtg_count_reg;
reg       rtg_active_reg;
reg       rtg_prev_reg;
wire      rtg_rise = s_rtg & ~rtg_prev_reg;
always @(posedge clk)
begin
   if (reset)
   begin
      rtg_prev_reg   <= 1'b0;
      rtg_active_reg <= 1'b0;
      rtg_count_reg  <= 8'h00;
   end
   else
   begin
      rtg_prev_reg <= s_rtg;
      if (rtg_rise & s_pwg)                            // RULE7
      begin
         rtg_active_reg <= 1'b1;
         rtg_count_reg  <= 8'h00;
      end
      else if (rtg_active_reg)
      begin
         rtg_count_reg <= rtg_count_reg + 8'h01;
         if (rtg_count_reg == FINE_DELAY[7:0] + SAMPLE_WIDTH[7:0] + MULT_DELAY[7:0])
            rtg_active_reg <= 1'b0;
      end
   end
end
wire phase_win = rtg_active_reg && rtg_count_reg >= SAMPLE_DELAY[7:0]
                 && rtg_count_reg < SAMPLE_DELAY[7:0] + SAMPLE_WIDTH[7:0];
wire fine_win  = rtg_active_reg && rtg_count_reg >= FINE_DELAY[7:0]
                 && rtg_count_reg < FINE_DELAY[7:0] + SAMPLE_WIDTH[7:0];
wire fine_end  = rtg_active_reg && rtg_count_reg == FINE_DELAY[7:0] + SAMPLE_WIDTH[7:0];
wire mult_go   = rtg_active_reg
                 && rtg_count_reg == FINE_DELAY[7:0] + SAMPLE_WIDTH[7:0] + MULT_DELAY[7:0];

// ----------------------------------------
// selected flags and test decode
// ----------------------------------------
always @(posedge clk)
begin
   if (reset)
   begin
      continuous_wave_flag <= 1'b0;
      sideband_flag        <= 1'b0;
      pulse_width_reset    <= 1'b0;
      start_trigger        <= 1'b0;
      test_control         <= 5'h00;
   end
   else
   begin
      continuous_wave_flag <= pod_mux(s_cw, s_pod);    // RULE1 RULE2
      sideband_flag        <= pod_mux(s_sb, s_pod);    // RULE1 RULE2
      pulse_width_reset    <= pod_mux(s_pwr, s_pod);   // RULE1 RULE3
      start_trigger        <= pod_mux(s_st, s_pod);    // RULE1 RULE3
      test_control         <= test_decode(s_dlow);     // RULE4
   end
end

// ----------------------------------------
// bus strobes and acknowledge
// ----------------------------------------
always @(posedge clk)
begin
   if (reset)
   begin
      read_strobe_a    <= 3'h0;
      write_strobe_a   <= 4'h0;
      read_strobe_b    <= 2'h0;
      write_strobe_b   <= 5'h00;
      load_acknowledge <= 1'b0;
   end
   else
   begin
      read_strobe_a    <= rd_a_next;                       // RULE9
      write_strobe_a   <= wr_a_next;                       // RULE9
      read_strobe_b    <= rd_b_next;                       // RULE10
      write_strobe_b   <= wr_b_next;                       // RULE10
      load_acknowledge <= read_load_reg | write_load_reg;  // RULE12
   end
end

// ----------------------------------------
// sample clocks, fine word and multiplier
// ----------------------------------------
always @(posedge clk)
begin
   if (reset)
   begin
      fine_freq_bus          <= 8'h00;
      phase_sample_clock     <= 1'b0;
      fine_freq_sample_clock <= 1'b0;
      mult_load              <= 1'b0;
      mult_start             <= 1'b0;
   end
   else
   begin
      if (fine_end)
         fine_freq_bus <= s_fine;                              // RULE5
      phase_sample_clock     <= phase_win & s_pwg;             // RULE7
      fine_freq_sample_clock <= fine_win & s_pwg;              // RULE7
      mult_load              <= fine_end;                      // RULE6
      mult_start             <= mult_go & ~pulse_width_reset;  // RULE6
   end
end

// ----------------------------------------
// byte buffers
// ----------------------------------------
always @(posedge clk)
begin
   if (reset)
   begin
      fine_buffer_data      <= 8'h00;
      fine_buffer_oe        <= 1'b0;
      retrigger_buffer_data <= 8'h00;
      retrigger_buffer_oe   <= 1'b0;
   end
   else
   begin
      fine_buffer_data      <= {7'h00, sideband_flag};   // RULE13
      retrigger_buffer_data <= {7'h00, sideband_flag};   // RULE13
      fine_buffer_oe        <= ~s_fstb_n & s_rstb_n;     // RULE14
      retrigger_buffer_oe   <= ~s_rstb_n & s_fstb_n;     // RULE14
   end
end

endmodule // rx_ctrl_bus

// >>> tb/rx_ctrl_bus_sva.sv
// Purpose: checker for rx_ctrl_bus
// Assumes: default delay parameters
// Notes:   flags lag pins by 3 edges, strobes by 4
`timescale 1ns/1ps
`include "rx_ctrl_regs.vh"
module rx_ctrl_bus_sva (
   input wire       clk,
   input wire       reset,
   input wire       pod_select,
   input wire [1:0] continuous_wave_flag_in,
   input wire [1:0] sideband_flag_in,
   input wire [2:0] bus_data_low,
   input wire [7:0] bus_address_bits,
   input wire       read_strobe_in,
   input wire       write_strobe_in,
   input wire       memory_access_enable,
   input wire       continuous_wave_flag,
   input wire       sideband_flag,
   input wire [4:0] test_control,
   input wire [2:0] read_strobe_a,
   input wire [4:0] write_strobe_b,
   input wire       load_acknowledge,
   input wire       phase_sample_clock,
   input wire       fine_freq_sample_clock,
   input wire [7:0] fine_buffer_data,
   input wire       fine_buffer_oe,
   input wire       retrigger_buffer_oe
);
   reg  [2:0] up_reg;
   wire [7:0] a  = bus_address_bits;
   wire       rd = read_strobe_in && !write_strobe_in && memory_access_enable;
   wire       wr = write_strobe_in && !read_strobe_in && memory_access_enable;
   wire       ok = up_reg == 3'h7;
   wire [4:0] tc = (bus_data_low >= 3'h1 && bus_data_low <= 3'h5) ? 5'h01 << (bus_data_low - 3'h1) : 5'h00;
   always @(posedge clk)
      if (reset)
         up_reg <= 3'h0;
      else if (!ok)
         up_reg <= up_reg + 3'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence phase_pulse;
      phase_sample_clock [*4] ##1 !phase_sample_clock;
   endsequence
   sequence fine_pulse;
      fine_freq_sample_clock [*4] ##1 !fine_freq_sample_clock;
   endsequence
   a_flag_select: assert property (ok |-> continuous_wave_flag == $past(continuous_wave_flag_in[pod_select], 3))
      else $error("continuous_wave_flag select");
   a_sideband_pass: assert property (ok |-> sideband_flag == $past(sideband_flag_in[pod_select], 3))
      else $error("sideband flag");
   a_test_decode: assert property (ok |-> test_control == $past(tc, 3))
      else $error("test decode");
   a_read_decode: assert property (ok |-> read_strobe_a == $past({rd && a == `ADDR_B4, rd && a == `ADDR_B2,
      rd && a == `ADDR_B0}, 4)) else $error("read strobe a");
   a_write_decode: assert property (ok |-> write_strobe_b == $past({wr && a == `ADDR_BC, wr && a == `ADDR_BA,
      wr && a == `ADDR_B8, wr && a == `ADDR_92, wr && a == `ADDR_90}, 4)) else $error("write strobe b");
   a_strobe_needs_load: assert property ((read_strobe_a != 3'h0 || write_strobe_b != 5'h00) |-> load_acknowledge)
      else $error("strobe without load");
   a_ack_from_load: assert property (ok |-> load_acknowledge == $past(rd || wr, 4))
      else $error("acknowledge");
   a_buffer_sideband: assert property (ok |-> fine_buffer_data == {7'h00, $past(sideband_flag)})
      else $error("buffer data");
   a_one_buffer: assert property (!(fine_buffer_oe && retrigger_buffer_oe))
      else $error("two buffers drive");
   a_sample_order: assert property ($rose(phase_sample_clock) |-> phase_pulse ##0 fine_pulse)
      else $error("sample clock order");
endmodule // rx_ctrl_bus_sva
bind rx_ctrl_bus rx_ctrl_bus_sva u_rx_ctrl_bus_sva (.clk, .reset, .pod_select, .continuous_wave_flag_in,
   .sideband_flag_in, .bus_data_low, .bus_address_bits, .read_strobe_in, .write_strobe_in, .memory_access_enable,
   .continuous_wave_flag, .sideband_flag, .test_control, .read_strobe_a, .write_strobe_b, .load_acknowledge,
   .phase_sample_clock, .fine_freq_sample_clock, .fine_buffer_data, .fine_buffer_oe, .retrigger_buffer_oe);

// >>> tb/cmd_proc_model.sv
// Purpose: command processor side of the strobe handshake
// Assumes: one access at a time, kind is {read, write, memory enable}
// Notes:   a released address shows its inverse
`timescale 1ns/1ps
module cmd_proc_model (
   input wire       clk,
   input wire       go,
   input wire [7:0] addr,
   input wire [2:0] kind,
   input wire       load_acknowledge,
   output reg [7:0] bus_address_bits = 8'h00,
   output reg       read_strobe_in = 1'b0,
   output reg       write_strobe_in = 1'b0,
   output reg       memory_access_enable = 1'b0,
   output reg       done = 1'b0
);
   integer wait_cnt = 0;
   always @(posedge clk)
   begin
      done <= 1'b0;
      if (go && wait_cnt == 0)
      begin
         bus_address_bits <= addr;
         {read_strobe_in, write_strobe_in, memory_access_enable} <= kind;
         wait_cnt <= 1;
      end
      else if (wait_cnt != 0 && (load_acknowledge || wait_cnt == 10))
      begin
         bus_address_bits <= ~bus_address_bits;
         {read_strobe_in, write_strobe_in, memory_access_enable} <= 3'h0;
         done <= 1'b1;
         wait_cnt <= 0;
      end
      else if (wait_cnt != 0)
         wait_cnt <= wait_cnt + 1;
   end
endmodule // cmd_proc_model

// >>> tb/rx_ctrl_bus_tb.sv
// Purpose: bench for rx_ctrl_bus
// Assumes: default delay parameters, 5 ns clock
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "rx_ctrl_regs.vh"
module rx_ctrl_bus_tb;
   reg clk = 1'b0, reset = 1'b1, pod_select = 1'b0, fine_freq_retrigger = 1'b0, pulse_gate_enable = 1'b0, go = 1'b0;
   reg fine_buffer_strobe_n = 1'b1, retrigger_buffer_strobe_n = 1'b1;
   reg [1:0] continuous_wave_flag_in = 2'h0, sideband_flag_in = 2'h0, pulse_width_reset_in = 2'h0, start_trigger_in = 2'h0;
   reg [2:0] bus_data_low = 3'h0, kind = 3'h0;
   reg [7:0] fine_freq_sample_bits = 8'ha6, addr = 8'h00;
   reg [3:0] seen;
   wire [7:0] bus_address_bits, fine_buffer_data, retrigger_buffer_data;
   wire [15:8] fine_freq_bus;
   wire [4:0] test_control, write_strobe_b;
   wire [3:0] write_strobe_a;
   wire [2:0] read_strobe_a;
   wire [1:0] read_strobe_b;
   wire read_strobe_in, write_strobe_in, memory_access_enable, done, continuous_wave_flag, sideband_flag, mult_load;
   wire pulse_width_reset, start_trigger, load_acknowledge, phase_sample_clock, fine_freq_sample_clock, mult_start;
   wire fine_buffer_oe, retrigger_buffer_oe;
   integer err_count = 0, compares = 0, cycles = 0, i, k, n_ph, n_fn;
   rx_ctrl_bus u_rx_ctrl_bus (.clk, .reset, .pod_select, .continuous_wave_flag_in, .sideband_flag_in,
      .pulse_width_reset_in, .start_trigger_in, .bus_data_low, .fine_freq_sample_bits, .bus_address_bits,
      .read_strobe_in, .write_strobe_in, .memory_access_enable, .fine_freq_retrigger, .pulse_gate_enable,
      .fine_buffer_strobe_n, .retrigger_buffer_strobe_n, .continuous_wave_flag, .sideband_flag, .pulse_width_reset,
      .start_trigger, .test_control, .fine_freq_bus, .read_strobe_a, .write_strobe_a, .read_strobe_b, .write_strobe_b,
      .load_acknowledge, .phase_sample_clock, .fine_freq_sample_clock, .mult_load, .mult_start, .fine_buffer_data,
      .fine_buffer_oe, .retrigger_buffer_data, .retrigger_buffer_oe);
   cmd_proc_model u_cmd_proc_model (.clk, .go, .addr, .kind, .load_acknowledge, .bus_address_bits, .read_strobe_in,
      .write_strobe_in, .memory_access_enable, .done);
   always #2.5 clk = ~clk;
   task check(input string what, input [15:0] exp, input [15:0] got);
      compares = compares + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task step(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function [13:0] exp_strobe(input [7:0] a, input [2:0] kd);
      reg r, w;
      begin
         r = kd == 3'h5;
         w = kd == 3'h3;
         exp_strobe = {r && a == `ADDR_B4, r && a == `ADDR_B2, r && a == `ADDR_B0, r && a == `ADDR_9A,
            r && a == `ADDR_96, w && a == `ADDR_B6, w && a == `ADDR_B4, w && a == `ADDR_B2, w && a == `ADDR_B0,
            w && a == `ADDR_BC, w && a == `ADDR_BA, w && a == `ADDR_B8, w && a == `ADDR_92, w && a == `ADDR_90};
      end
   endfunction
   task access(input [7:0] a, input [2:0] kd);
      integer j;
      addr = a;
      kind = kd;
      go = 1'b1;
      step(1);
      go = 1'b0;
      for (j = 0; j < 16 && done !== 1'b1; j = j + 1)
         step(1);
      check("strobes", exp_strobe(a, kd), {read_strobe_a, read_strobe_b, write_strobe_a, write_strobe_b});
      check("ack", kd == 3'h5 || kd == 3'h3, load_acknowledge);
      step(6);
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 40000)
      begin
         err_count = err_count + 1;
         end_of_test;
      end
   end
   initial
   begin
      step(3);
      check("reset", 16'h0, {load_acknowledge, test_control, phase_sample_clock, fine_buffer_oe, mult_start});
      reset = 1'b0;
      for (k = 0; k < 8; k = k + 1)
      begin
         pod_select = k[0];
         continuous_wave_flag_in = k[2:1];
         sideband_flag_in = ~k[2:1];
         pulse_width_reset_in = {k[1], k[2]};
         start_trigger_in = k[2:1] ^ 2'h1;
         bus_data_low = k[2:0];
         step(4);
         check("flags", {continuous_wave_flag_in[k[0]], sideband_flag_in[k[0]], pulse_width_reset_in[k[0]],
            start_trigger_in[k[0]]}, {continuous_wave_flag, sideband_flag, pulse_width_reset, start_trigger});
         check("test", (k >= 1 && k <= 5) ? (5'h01 << (k - 1)) : 5'h00, test_control);
         check("buffer", {7'h00, sideband_flag_in[k[0]], 7'h00, sideband_flag_in[k[0]]},
            {fine_buffer_data, retrigger_buffer_data});
      end
      for (k = 0; k < 4; k = k + 1)
      begin
         fine_buffer_strobe_n = k[0];
         retrigger_buffer_strobe_n = k[1];
         step(4);
         check("oe", {!k[0] && k[1], !k[1] && k[0]}, {fine_buffer_oe, retrigger_buffer_oe});
      end
      $display("test flags done");
      pulse_width_reset_in = 2'h0;
      for (k = 0; k < 2; k = k + 1)
      begin
         pulse_gate_enable = k[0];
         step(4);
         fine_freq_retrigger = 1'b1;
         seen = 4'h0;
         n_ph = 0;
         n_fn = 0;
         for (i = 0; i < 30; i = i + 1)
         begin
            step(1);
            seen = seen | {mult_load, mult_start, phase_sample_clock, fine_freq_sample_clock};
            n_ph = n_ph + phase_sample_clock;
            n_fn = n_fn + fine_freq_sample_clock;
         end
         fine_freq_retrigger = 1'b0;
         check("clocks", {4{k[0]}}, seen);
         check("phase width", k[0] ? `SAMPLE_WIDTH_CYC : 0, n_ph);
         check("fine width", k[0] ? `SAMPLE_WIDTH_CYC : 0, n_fn);
         check("fine bus", k[0] ? 8'ha6 : 8'h00, fine_freq_bus);
      end
      $display("test sample done");
      for (k = 0; k < 4; k = k + 1)
         for (i = 0; i < 256; i = i + 1)
            access(i[7:0], (k == 0) ? 3'h5 : (k == 1) ? 3'h3 : (k == 2) ? 3'h4 : 3'h7);
      $display("test strobes done");
      end_of_test;
   end
endmodule // rx_ctrl_bus_tb
